// ===== hdl/rxafb_pkg.sv
// constants and types of the receive frame builder
package rxafb_pkg;
    // ----------------------------------------
    // frame bytes
    // ----------------------------------------
    localparam logic [7:0] RXAFB_DELIM = 8'h7E;
    localparam logic [7:0] RXAFB_TYPE_PLAIN = 8'h90;
    localparam logic [7:0] RXAFB_TYPE_EXPL = 8'h91;
    localparam logic [7:0] RXAFB_TYPE_SAMPLE = 8'h92;
    localparam logic [7:0] RXAFB_RSV_BYTE = 8'h00;
    localparam logic [7:0] RXAFB_SMP_RSV_HI = 8'hFF;
    localparam logic [7:0] RXAFB_SMP_RSV_LO = 8'hFE;
    localparam logic [7:0] RXAFB_CKS_BASE = 8'hFF;
    // ----------------------------------------
    // frame offsets
    // ----------------------------------------
    localparam logic [7:0] RXAFB_OFS_LEN_HI = 8'h01;
    localparam logic [7:0] RXAFB_OFS_LEN_LO = 8'h02;
    localparam logic [7:0] RXAFB_OFS_TYPE = 8'h03;
    localparam logic [7:0] RXAFB_OFS_ADDR = 8'h04;
    localparam logic [7:0] RXAFB_OFS_ADDR_END = 8'h0B;
    localparam logic [7:0] RXAFB_OFS_SMP_RSV = 8'h0C;
    localparam logic [7:0] RXAFB_OFS_SMP_RSV2 = 8'h0D;
    localparam logic [7:0] RXAFB_OFS_SRC_EP = 8'h0E;
    localparam logic [7:0] RXAFB_OFS_DST_EP = 8'h0F;
    localparam logic [7:0] RXAFB_OFS_CLUSTER = 8'h10;
    localparam logic [7:0] RXAFB_OFS_PROFILE = 8'h12;
    localparam logic [7:0] RXAFB_OFS_PLAIN_DATA = 8'h0F;
    localparam logic [7:0] RXAFB_OFS_EXPL_DATA = 8'h15;
    localparam logic [7:0] RXAFB_OFS_RXOPT = 8'h0E;
    localparam logic [7:0] RXAFB_OFS_NSAMP = 8'h0F;
    localparam logic [7:0] RXAFB_OFS_DMASK = 8'h10;
    localparam logic [7:0] RXAFB_OFS_AMASK = 8'h12;
    localparam logic [7:0] RXAFB_OFS_DSAMP = 8'h13;
    localparam logic [7:0] RXAFB_HDR_TAIL = 8'h03;
    // length counts bytes from the type byte up to the data
    localparam logic [15:0] RXAFB_LEN_PLAIN = 16'h000C;
    localparam logic [15:0] RXAFB_LEN_EXPL = 16'h0012;
    localparam logic [15:0] RXAFB_LEN_SAMPLE = 16'h0010;
    // ----------------------------------------
    // payload store and sample fields
    // ----------------------------------------
    localparam int RXAFB_PAY_DEPTH = 64;
    localparam logic [6:0] RXAFB_PAY_FULL = 7'h40;
    localparam logic [15:0] RXAFB_DMASK_LINES = 16'h1FFF;
    localparam logic [7:0] RXAFB_AMASK_USED = 8'h8F;
    localparam logic [7:0] RXAFB_RXOPT_USED = 8'h03;
    localparam logic [7:0] RXAFB_NSAMP_RST = 8'h01;
    localparam int RXAFB_ANA_CH = 4;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam int RXAFB_AW = 12;
    localparam logic [11:0] RXAFB_REG_CTRL = 12'h000;
    localparam logic [11:0] RXAFB_REG_SRC_LO = 12'h004;
    localparam logic [11:0] RXAFB_REG_SRC_HI = 12'h008;
    localparam logic [11:0] RXAFB_REG_EXPL = 12'h00C;
    localparam logic [11:0] RXAFB_REG_PROF = 12'h010;
    localparam logic [11:0] RXAFB_REG_SMP_HDR = 12'h014;
    localparam logic [11:0] RXAFB_REG_SMP_DAT = 12'h018;
    localparam logic [11:0] RXAFB_REG_ANA01 = 12'h01C;
    localparam logic [11:0] RXAFB_REG_ANA23 = 12'h020;
    localparam logic [11:0] RXAFB_REG_PAYLOAD = 12'h024;
    localparam logic [11:0] RXAFB_REG_CMD = 12'h028;
    localparam logic [11:0] RXAFB_REG_STATUS = 12'h02C;
    localparam int RXAFB_CTRL_API_BIT = 8;
    localparam int RXAFB_OPT_EXPL_BIT = 1;
    localparam int RXAFB_CMD_RF_BIT = 0;
    localparam int RXAFB_CMD_SMP_BIT = 1;
    localparam logic [7:0] RXAFB_OPT_RST = 8'h00;
    localparam logic RXAFB_API_RST = 1'b1;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        RXAFB_K_PLAIN,
        RXAFB_K_EXPL,
        RXAFB_K_SAMPLE
    } rxafb_kind_t;
endpackage

// ===== hdl/rxafb_cksum.sv
// running checksum over the frame body
`timescale 1ns/1ps
module rxafb_cksum
    import rxafb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    input wire logic add,
    input wire logic [7:0] din,
    output logic [7:0] cks
);
    logic [7:0] sum_q;
    logic [7:0] sum_now;

    // ----------------------------------------
    // accumulate
    // ----------------------------------------
    assign sum_now = add ? 8'(sum_q + din) : sum_q;
    assign cks = 8'(RXAFB_CKS_BASE - sum_now);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum_q <= 8'h00;
        end else if (clr) begin
            sum_q <= 8'h00;
        end else begin
            sum_q <= sum_now;
        end
    end
endmodule

// ===== hdl/rxafb_top.sv
// receive frame builder: apb registers and framed byte stream
`timescale 1ns/1ps
module rxafb_top
    import rxafb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rxafb_pkg::RXAFB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready
);
    import rxafb_pkg::*;

    typedef enum logic {RXAFB_S_IDLE, RXAFB_S_SEND} rxafb_state_t;

    // ----------------------------------------
    // sample tail: digital word then analog words
    // ----------------------------------------
    function automatic logic [83:0] tail_of(input logic [15:0] dm,
        input logic [15:0] ds, input logic [7:0] am,
        input logic [63:0] an);
        logic [79:0] t;
        logic [3:0] n;
        logic [15:0] dv;
        t = '0;
        n = 4'h0;
        dv = ds & dm & RXAFB_DMASK_LINES;
        if (dm != 16'h0000) begin
            t[7:0] = dv[15:8];
            t[15:8] = dv[7:0];
            n = 4'h2;
        end
        for (int c = 0; c < RXAFB_ANA_CH; c++) begin
            if (am[c]) begin
                t[8*n +: 8] = an[16*c+8 +: 8];
                t[8*n+8 +: 8] = an[16*c +: 8];
                n = 4'(n + 4'h2);
            end
        end
        return {n, t};
    endfunction

    rxafb_state_t state_q;
    rxafb_kind_t kind_q;
    logic [7:0] opt_q;
    logic api_q;
    logic [63:0] src_q;
    logic [7:0] sep_q;
    logic [7:0] dep_q;
    logic [15:0] clu_q;
    logic [15:0] prof_q;
    logic [7:0] rxopt_q;
    logic [7:0] nsamp_q;
    logic [15:0] dmask_q;
    logic [7:0] amask_q;
    logic [15:0] dsamp_q;
    logic [63:0] ana_q;
    logic [7:0] pay_mem [RXAFB_PAY_DEPTH];
    logic [6:0] pay_cnt_q;
    logic [79:0] tail_q;
    logic [15:0] len_q;
    logic [7:0] last_q;
    logic [7:0] cur_q;
    logic [7:0] tx_data_q;
    logic [7:0] frames_q;
    logic [7:0] drops_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_val;
    logic mapped;
    logic wr;
    logic cfg_we;
    logic busy;
    logic hs;
    logic done;
    logic start_rf;
    logic start_smp;
    logic smp_ok;
    logic drop;
    logic start;
    logic [83:0] tail_new;
    logic [7:0] nxt;
    logic [7:0] nb;
    logic [7:0] ai;
    logic [7:0] pi;
    logic [7:0] ti;
    logic cks_add;
    logic [7:0] cks_val;

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    assign busy = (state_q == RXAFB_S_SEND);
    assign wr = psel && penable && pwrite;
    assign cfg_we = wr && !busy;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_q;

    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (paddr)
            RXAFB_REG_CTRL: rd_val = {23'h0, api_q, opt_q};
            RXAFB_REG_SRC_LO: rd_val = src_q[31:0];
            RXAFB_REG_SRC_HI: rd_val = src_q[63:32];
            RXAFB_REG_EXPL: rd_val = {clu_q, dep_q, sep_q};
            RXAFB_REG_PROF: rd_val = {16'h0, prof_q};
            RXAFB_REG_SMP_HDR: rd_val = {dmask_q, nsamp_q, rxopt_q};
            RXAFB_REG_SMP_DAT: rd_val = {dsamp_q, 8'h00, amask_q};
            RXAFB_REG_ANA01: rd_val = ana_q[31:0];
            RXAFB_REG_ANA23: rd_val = ana_q[63:32];
            RXAFB_REG_PAYLOAD: rd_val = {25'h0, pay_cnt_q};
            RXAFB_REG_CMD: rd_val = 32'h0000_0000;
            RXAFB_REG_STATUS: rd_val = {8'h00, drops_q, frames_q, 7'h00, busy};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rd_val;
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_q <= RXAFB_OPT_RST;
            api_q <= RXAFB_API_RST;
            src_q <= 64'h0;
            sep_q <= 8'h00;
            dep_q <= 8'h00;
            clu_q <= 16'h0000;
            prof_q <= 16'h0000;
            rxopt_q <= 8'h00;
            nsamp_q <= RXAFB_NSAMP_RST;
            dmask_q <= 16'h0000;
            amask_q <= 8'h00;
            dsamp_q <= 16'h0000;
            ana_q <= 64'h0;
        end else if (cfg_we) begin
            unique case (paddr)
                RXAFB_REG_CTRL: begin
                    opt_q <= pwdata[7:0];
                    api_q <= pwdata[RXAFB_CTRL_API_BIT];
                end
                RXAFB_REG_SRC_LO: src_q[31:0] <= pwdata;
                RXAFB_REG_SRC_HI: src_q[63:32] <= pwdata;
                RXAFB_REG_EXPL: begin
                    sep_q <= pwdata[7:0];
                    dep_q <= pwdata[15:8];
                    clu_q <= pwdata[31:16];
                end
                RXAFB_REG_PROF: prof_q <= pwdata[15:0];
                RXAFB_REG_SMP_HDR: begin
                    rxopt_q <= pwdata[7:0] & RXAFB_RXOPT_USED;
                    nsamp_q <= pwdata[15:8];
                    dmask_q <= pwdata[31:16] & RXAFB_DMASK_LINES;
                end
                RXAFB_REG_SMP_DAT: begin
                    amask_q <= pwdata[7:0] & RXAFB_AMASK_USED;
                    dsamp_q <= pwdata[31:16];
                end
                RXAFB_REG_ANA01: ana_q[31:0] <= pwdata;
                RXAFB_REG_ANA23: ana_q[63:32] <= pwdata;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // payload store
    // ----------------------------------------
    always_ff @(posedge pclk) begin
        if (cfg_we && paddr == RXAFB_REG_PAYLOAD
            && pay_cnt_q != RXAFB_PAY_FULL) begin
            pay_mem[pay_cnt_q[5:0]] <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pay_cnt_q <= 7'h00;
        end else if (done && kind_q != RXAFB_K_SAMPLE) begin
            pay_cnt_q <= 7'h00;
        end else if (cfg_we && paddr == RXAFB_REG_PAYLOAD
            && pay_cnt_q != RXAFB_PAY_FULL) begin
            pay_cnt_q <= 7'(pay_cnt_q + 7'h01);
        end
    end

    // ----------------------------------------
    // frame start
    // ----------------------------------------
    assign start_rf = cfg_we && paddr == RXAFB_REG_CMD
        && pwdata[RXAFB_CMD_RF_BIT];
    assign start_smp = cfg_we && paddr == RXAFB_REG_CMD
        && pwdata[RXAFB_CMD_SMP_BIT] && !start_rf;
    assign smp_ok = (opt_q == 8'h00) && api_q;
    assign drop = start_smp && !smp_ok;
    assign start = start_rf || (start_smp && smp_ok);
    assign tail_new = tail_of(dmask_q, dsamp_q, amask_q, ana_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kind_q <= RXAFB_K_PLAIN;
            len_q <= 16'h0000;
            last_q <= 8'h00;
            tail_q <= 80'h0;
        end else if (start_rf && opt_q[RXAFB_OPT_EXPL_BIT]) begin
            kind_q <= RXAFB_K_EXPL;
            len_q <= RXAFB_LEN_EXPL + 16'(pay_cnt_q);
            last_q <= 8'(RXAFB_LEN_EXPL[7:0] + pay_cnt_q + RXAFB_HDR_TAIL);
        end else if (start_rf) begin
            kind_q <= RXAFB_K_PLAIN;
            len_q <= RXAFB_LEN_PLAIN + 16'(pay_cnt_q);
            last_q <= 8'(RXAFB_LEN_PLAIN[7:0] + pay_cnt_q + RXAFB_HDR_TAIL);
        end else if (start) begin
            kind_q <= RXAFB_K_SAMPLE;
            tail_q <= tail_new[79:0];
            len_q <= RXAFB_LEN_SAMPLE + 16'(tail_new[83:80]);
            last_q <= 8'(RXAFB_LEN_SAMPLE[7:0] + tail_new[83:80]
                + RXAFB_HDR_TAIL);
        end
    end

    // ----------------------------------------
    // byte sequencer
    // ----------------------------------------
    assign hs = busy && tx_ready;
    assign done = hs && (cur_q == last_q);
    assign tx_valid = busy;
    assign tx_data = tx_data_q;
    assign nxt = 8'(cur_q + 8'h01);
    assign cks_add = hs && cur_q >= RXAFB_OFS_TYPE;

    rxafb_cksum u_cksum (
        .pclk(pclk),
        .presetn(presetn),
        .clr(start),
        .add(cks_add),
        .din(tx_data_q),
        .cks(cks_val)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= RXAFB_S_IDLE;
            cur_q <= 8'h00;
            tx_data_q <= 8'h00;
        end else if (start) begin
            state_q <= RXAFB_S_SEND;
            cur_q <= 8'h00;
            tx_data_q <= RXAFB_DELIM;
        end else if (done) begin
            state_q <= RXAFB_S_IDLE;
        end else if (hs) begin
            cur_q <= nxt;
            tx_data_q <= nb;
        end
    end

    // ----------------------------------------
    // byte at the next offset
    // ----------------------------------------
    assign ai = 8'(RXAFB_OFS_ADDR_END - nxt);
    assign pi = 8'(nxt - (kind_q == RXAFB_K_EXPL ? RXAFB_OFS_EXPL_DATA
        : RXAFB_OFS_PLAIN_DATA));
    assign ti = 8'(nxt - RXAFB_OFS_DSAMP);

    always_comb begin
        nb = RXAFB_RSV_BYTE;
        if (nxt == last_q) begin
            nb = cks_val;
        end else if (nxt == RXAFB_OFS_LEN_HI) begin
            nb = len_q[15:8];
        end else if (nxt == RXAFB_OFS_LEN_LO) begin
            nb = len_q[7:0];
        end else if (nxt == RXAFB_OFS_TYPE) begin
            unique case (kind_q)
                RXAFB_K_PLAIN: nb = RXAFB_TYPE_PLAIN;
                RXAFB_K_EXPL: nb = RXAFB_TYPE_EXPL;
                RXAFB_K_SAMPLE: nb = RXAFB_TYPE_SAMPLE;
                default: nb = RXAFB_RSV_BYTE;
            endcase
        end else if (nxt <= RXAFB_OFS_ADDR_END) begin
            nb = src_q[{ai[2:0], 3'b000} +: 8];
        end else begin
            unique case (kind_q)
                RXAFB_K_PLAIN: begin
                    if (nxt >= RXAFB_OFS_PLAIN_DATA) begin
                        nb = pay_mem[pi[5:0]];
                    end
                end
                RXAFB_K_EXPL: begin
                    if (nxt >= RXAFB_OFS_EXPL_DATA) begin
                        nb = pay_mem[pi[5:0]];
                    end else if (nxt == RXAFB_OFS_SRC_EP) begin
                        nb = sep_q;
                    end else if (nxt == RXAFB_OFS_DST_EP) begin
                        nb = dep_q;
                    end else if (nxt == RXAFB_OFS_CLUSTER) begin
                        nb = clu_q[15:8];
                    end else if (nxt == 8'(RXAFB_OFS_CLUSTER + 8'h01)) begin
                        nb = clu_q[7:0];
                    end else if (nxt == RXAFB_OFS_PROFILE) begin
                        nb = prof_q[15:8];
                    end else if (nxt == 8'(RXAFB_OFS_PROFILE + 8'h01)) begin
                        nb = prof_q[7:0];
                    end
                end
                RXAFB_K_SAMPLE: begin
                    if (nxt >= RXAFB_OFS_DSAMP) begin
                        nb = tail_q[{ti[3:0], 3'b000} +: 8];
                    end else if (nxt == RXAFB_OFS_SMP_RSV) begin
                        nb = RXAFB_SMP_RSV_HI;
                    end else if (nxt == RXAFB_OFS_SMP_RSV2) begin
                        nb = RXAFB_SMP_RSV_LO;
                    end else if (nxt == RXAFB_OFS_RXOPT) begin
                        nb = rxopt_q;
                    end else if (nxt == RXAFB_OFS_NSAMP) begin
                        nb = nsamp_q;
                    end else if (nxt == RXAFB_OFS_DMASK) begin
                        nb = dmask_q[15:8];
                    end else if (nxt == 8'(RXAFB_OFS_DMASK + 8'h01)) begin
                        nb = dmask_q[7:0];
                    end else if (nxt == RXAFB_OFS_AMASK) begin
                        nb = amask_q;
                    end
                end
                default: nb = RXAFB_RSV_BYTE;
            endcase
        end
    end

    // ----------------------------------------
    // statistics
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frames_q <= 8'h00;
            drops_q <= 8'h00;
        end else begin
            if (done) begin
                frames_q <= 8'(frames_q + 8'h01);
            end
            if (drop) begin
                drops_q <= 8'(drops_q + 8'h01);
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [7:0] h_sum_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h_sum_q <= 8'h00;
        end else if (start) begin
            h_sum_q <= 8'h00;
        end else if (hs && cur_q >= RXAFB_OFS_TYPE) begin
            h_sum_q <= 8'(h_sum_q + tx_data_q);
        end
    end

    property p_delim;
        @(posedge pclk) disable iff (!presetn)
        $rose(tx_valid) |-> tx_data == RXAFB_DELIM && cur_q == 8'h00;
    endproperty
    a_delim: assert property (p_delim) else $error("no start byte");

    property p_len;
        @(posedge pclk) disable iff (!presetn)
        tx_valid && cur_q == RXAFB_OFS_LEN_LO
            |-> tx_data == len_q[7:0] && last_q == 8'(len_q[7:0] + 8'h03);
    endproperty
    a_len: assert property (p_len) else $error("length mismatch");

    property p_cks;
        @(posedge pclk) disable iff (!presetn)
        tx_valid && cur_q == last_q |-> 8'(tx_data + h_sum_q) == 8'hFF;
    endproperty
    a_cks: assert property (p_cks) else $error("bad checksum");

    property p_plain;
        @(posedge pclk) disable iff (!presetn)
        start_rf && opt_q == 8'h00 |=> kind_q == RXAFB_K_PLAIN && tx_valid;
    endproperty
    a_plain: assert property (p_plain) else $error("plain type wrong");

    property p_expl;
        @(posedge pclk) disable iff (!presetn)
        start_rf && opt_q[RXAFB_OPT_EXPL_BIT]
            |=> kind_q == RXAFB_K_EXPL && tx_valid;
    endproperty
    a_expl: assert property (p_expl) else $error("explicit not chosen");

    property p_smp_drop;
        @(posedge pclk) disable iff (!presetn)
        drop && !busy |=> !tx_valid && drops_q == $past(drops_q) + 8'h01;
    endproperty
    a_smp_drop: assert property (p_smp_drop) else $error("sample not held");

    property p_addr;
        @(posedge pclk) disable iff (!presetn)
        tx_valid && cur_q == RXAFB_OFS_ADDR |-> tx_data == src_q[63:56];
    endproperty
    a_addr: assert property (p_addr) else $error("address byte wrong");

    property p_ep;
        @(posedge pclk) disable iff (!presetn)
        tx_valid && kind_q == RXAFB_K_EXPL && cur_q == RXAFB_OFS_SRC_EP
            |-> tx_data == sep_q;
    endproperty
    a_ep: assert property (p_ep) else $error("endpoint wrong");

    property p_dmask;
        @(posedge pclk) disable iff (!presetn)
        tx_valid && kind_q == RXAFB_K_SAMPLE && cur_q == RXAFB_OFS_DMASK
            |-> tx_data[7:5] == 3'b000;
    endproperty
    a_dmask: assert property (p_dmask) else $error("mask top bits set");
endmodule

// ===== verification/rxafb_host.sv
// host model: takes framed bytes, stalling one cycle in four
`timescale 1ns/1ps
module rxafb_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    logic [7:0] got[$];
    logic [1:0] ph_q;
    logic [7:0] fsum;
    logic [15:0] flen;
    int pos = 0, good = 0, bad = 0;
    assign tx_ready = (ph_q != 2'h3);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ph_q <= 2'h0;
        else ph_q <= ph_q + 2'h1;
    end
    always @(posedge pclk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
            if (pos == 0) begin
                fsum = 8'h00;
                if (tx_data == 8'h7E) pos = 1;
            end else if (pos < 3) begin
                flen = {flen[7:0], tx_data};
                pos++;
            end else if (pos < flen + 3) begin
                fsum += tx_data;
                pos++;
            end else begin
                if (8'(fsum + tx_data) == 8'hFF) good++;
                else bad++;
                pos = 0;
            end
        end
    end
endmodule

// ===== verification/tb.sv
// testbench of the receive frame builder
`timescale 1ns/1ps
module tb;
    import rxafb_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, tx_valid, tx_ready, er;
    logic [7:0] tx_data, rxo, cnt, am, eps, epd;
    logic [15:0] dm, ds, clu, prof, w;
    logic [15:0] an[4];
    logic [63:0] src;
    logic [7:0] pay[$], body[$], exp_q[$];
    int errors = 0, n_compared = 0, seed = 20, i, n;
    always #50 pclk = ~pclk;
    rxafb_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready));
    rxafb_host host (.pclk(pclk), .presetn(presetn), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready));
    // ----
    // bus and check tasks
    // ----
    task stop_test;
        if (errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge pclk);
            k++;
        end
        if (k == 20) begin
            chk(1'b0, "apb timeout");
            stop_test;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task idle;
        for (int k = 0; k < 300; k++) begin
            apb(1'b0, RXAFB_REG_STATUS, 32'h0);
            if (rd[0] === 1'b0) return;
        end
        chk(1'b0, "busy timeout");
        stop_test;
    endtask
    task mk(input rxafb_kind_t k);
        logic [7:0] s;
        s = 8'h00;
        w = ds & dm;
        body = {k == RXAFB_K_PLAIN ? RXAFB_TYPE_PLAIN : k == RXAFB_K_EXPL ?
            RXAFB_TYPE_EXPL : RXAFB_TYPE_SAMPLE};
        for (n = 7; n >= 0; n--) body.push_back(src[n*8+:8]);
        if (k == RXAFB_K_PLAIN) body = {body, 8'h00, 8'h00, 8'h00, pay};
        else if (k == RXAFB_K_EXPL) body = {body, 8'h00, 8'h00, eps, epd,
            clu[15:8], clu[7:0], prof[15:8], prof[7:0], 8'h00, pay};
        else begin
            body = {body, 8'hFF, 8'hFE, rxo, cnt, dm[15:8], dm[7:0], am};
            if (dm != 16'h0) body = {body, w[15:8], w[7:0]};
            for (n = 0; n < 4; n++)
                if (am[n]) body = {body, an[n][15:8], an[n][7:0]};
        end
        foreach (body[j]) s += body[j];
        exp_q = {8'h7E, 8'(body.size() >> 8), 8'(body.size()), body,
            8'hFF - s};
    endtask
    task rnd(input int np);
        src = {$random(seed), $random(seed)};
        {clu, epd, eps} = $random(seed);
        {ds, prof} = $random(seed);
        {an[1], an[0]} = $random(seed);
        {an[3], an[2]} = $random(seed);
        {dm, cnt, rxo} = $random(seed);
        dm &= RXAFB_DMASK_LINES;
        rxo &= 8'h03;
        am = 8'($random(seed)) & 8'h8F;
        pay = {};
        repeat (np) pay.push_back(8'($random(seed)));
    endtask
    task run(input rxafb_kind_t k);
        host.got = {};
        apb(1'b1, RXAFB_REG_SRC_LO, src[31:0]);
        apb(1'b1, RXAFB_REG_SRC_HI, src[63:32]);
        apb(1'b1, RXAFB_REG_EXPL, {clu, epd, eps});
        apb(1'b1, RXAFB_REG_PROF, {16'h0, prof});
        apb(1'b1, RXAFB_REG_SMP_HDR, {dm, cnt, rxo});
        apb(1'b1, RXAFB_REG_SMP_DAT, {ds, 8'h00, am});
        apb(1'b1, RXAFB_REG_ANA01, {an[1], an[0]});
        apb(1'b1, RXAFB_REG_ANA23, {an[3], an[2]});
        foreach (pay[j]) apb(1'b1, RXAFB_REG_PAYLOAD, {24'h0, pay[j]});
        apb(1'b1, RXAFB_REG_CMD, k == RXAFB_K_SAMPLE ? 32'h2 :
            i[1] ? 32'h3 : 32'h1);
        apb(1'b1, RXAFB_REG_SRC_LO, ~src[31:0]); // ignored while busy
        idle;
        mk(k);
        chk(host.got.size() == exp_q.size(), "frame size");
        foreach (exp_q[j]) chk(host.got[j] === exp_q[j], "frame byte");
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, RXAFB_REG_CTRL, 32'h0);
        chk(rd === 32'h0000_0100, "ctrl reset value");
        chk(er === 1'b0 && pready === 1'b1, "mapped access");
        apb(1'b1, 12'h030, 32'h1);
        chk(er === 1'b1, "unmapped access");
        for (i = 0; i < 6; i++) begin
            rnd(i == 5 ? 64 : i * 9 + 1);
            apb(1'b1, RXAFB_REG_CTRL, i[0] ? 32'h102 : 32'h100);
            run(i[0] ? RXAFB_K_EXPL : RXAFB_K_PLAIN);
        end
        apb(1'b1, RXAFB_REG_CTRL, 32'h100);
        for (i = 0; i < 5; i++) begin
            rnd(0);
            if (i == 0) {dm, am} = 24'h0;
            if (i == 1) {dm, am} = {16'h1FFF, 8'h8F};
            run(RXAFB_K_SAMPLE);
        end
        for (i = 0; i < 2; i++) begin
            apb(1'b1, RXAFB_REG_CTRL, i ? 32'h101 : 32'h000);
            host.got = {};
            apb(1'b1, RXAFB_REG_CMD, 32'h2);
            idle;
            chk(host.got.size() == 0, "sample not dropped");
            chk(rd[23:16] === 8'(i + 1), "drop count");
        end
        chk(rd[15:8] === 8'd11, "frames sent count");
        chk(host.bad == 0 && host.good == 11, "host checksum");
        stop_test;
    end
endmodule
